/* File: hdl/hpm_pin_mux.sv */
// Host port mode selection, report interrupt and downstream pin mux
`timescale 1ns/100ps
module hpm_pin_mux import hpm_pkg::*; (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_b_in,
  input  wire logic                 link_clk_in,
  input  wire logic                 link_report_read_in,
  input  wire logic                 report_post_in,
  output logic                      report_pending_irq_n_out,
  output logic                      report_pending_irq_n_oe_out,
  output logic      [PEND_W-1:0]    pending_count_out,
  input  wire logic                 host_data_or_spi_clock_pin_in,
  output logic                      host_data_or_spi_clock_pin_out,
  output logic                      host_data_or_spi_clock_pin_oe_out,
  input  wire logic                 host_clock_or_select_pin_in,
  output logic                      host_clock_or_select_pin_out,
  output logic                      host_clock_or_select_pin_oe_out,
  input  wire logic                 addr_select_or_host_in_pin_in,
  input  wire logic                 iface_strap_or_host_out_pin_in,
  output logic                      iface_strap_or_host_out_pin_out,
  output logic                      iface_strap_or_host_out_pin_oe_out,
  input  wire hpm_host_tx_t         host_tx_in,
  output hpm_host_rx_t              host_rx_out,
  output logic                      host_spi_mode_out,
  input  wire hpm_ds_mode_t         ds_mode_in,
  input  wire hpm_ds_tx_t           ds_tx_in,
  output hpm_ds_rx_t                ds_rx_out,
  input  wire logic [DS_N-1:0]      downstream_port_pin_in,
  output logic      [DS_N-1:0]      downstream_port_pin_out,
  output logic      [DS_N-1:0]      downstream_port_pin_oe_out,
  input  wire logic [GPIO_N-1:0]    general_io_pins_in,
  input  wire logic [GPIO_N-1:0]    general_io_drive_in,
  input  wire logic [GPIO_N-1:0]    general_io_dir_in,
  input  wire logic                 hsync_en_in,
  input  wire logic                 ext_sync_en_in,
  output logic      [GPIO_N-1:0]    general_io_pins_out,
  output logic      [GPIO_N-1:0]    general_io_pins_oe_out,
  output logic      [GPIO_N-1:0]    general_io_val_out,
  output logic                      hsync_out,
  output logic                      external_sync_input_out,
  input  wire logic [A_REMAP_N-1:0] a_upper_remap_in,
  output logic      [A_REMAP_N-1:0] a_upper_remap_out,
  input  wire logic                 force_multi_in,
  output logic      [AUX_N-1:0]     force_chan_en_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 4 + DS_N + GPIO_N;

  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s;
  logic              host_a_s;
  logic              host_b_s;
  logic              addr_s;
  logic              strap_s;
  logic [DS_N-1:0]   ds_s;
  logic [GPIO_N-1:0] gpio_s;

  assign pin_raw = {host_data_or_spi_clock_pin_in, host_clock_or_select_pin_in,
                    addr_select_or_host_in_pin_in, iface_strap_or_host_out_pin_in,
                    downstream_port_pin_in, general_io_pins_in};

  hpm_sync2 #(.W(PIN_W)) u_pin_sync (
    .clk_in (core_clk_in),
    .d_in   (pin_raw),
    .q_out  (pin_s)
  );

  assign {host_a_s, host_b_s, addr_s, strap_s, ds_s, gpio_s} = pin_s;

  // ----------------------------------------------------------------
  // Link domain: host read events
  // ----------------------------------------------------------------
  // The link clock may stop between transfers, so the read event is
  // carried as a toggle level rather than a pulse.
  logic link_rst_b;
  logic link_tog;
  logic tog_s;
  logic tog_d;
  logic consume;

  hpm_sync2 #(.W(1)) u_link_rst_sync (
    .clk_in (link_clk_in),
    .d_in   (rst_b_in),
    .q_out  (link_rst_b)
  );

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_b) begin
      link_tog <= 1'b0;
    end else if (link_report_read_in) begin
      link_tog <= !link_tog;
    end
  end

  hpm_sync2 #(.W(1)) u_tog_sync (
    .clk_in (core_clk_in),
    .d_in   (link_tog),
    .q_out  (tog_s)
  );

  // Tracks the synced level in reset too: the link side may miss a short
  // reset, and a stale toggle must not look like a host read afterwards.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      tog_d <= tog_s;
    end else begin
      tog_d <= tog_s;
    end
  end

  assign consume = tog_s ^ tog_d;

  // ----------------------------------------------------------------
  // Pending reports and interrupt pin
  // ----------------------------------------------------------------
  logic pend;

  hpm_pend_ctr u_pend (
    .clk_in     (core_clk_in),
    .rst_b_in   (rst_b_in),
    .post_in    (report_post_in),
    .consume_in (consume),
    .count_out  (pending_count_out)
  );

  assign pend = (pending_count_out != PEND_ZERO);

  // Open drain: only ever pulls low; the pull-up restores high.
  // The pin holds low for as long as reports remain, suiting a host
  // that samples the level.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      report_pending_irq_n_oe_out <= RST_IRQ_OE;
      report_pending_irq_n_out    <= 1'b0;
    end else begin
      report_pending_irq_n_oe_out <= pend;
      report_pending_irq_n_out    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  hpm_strap_st_t strap_st;
  logic          host_spi;

  // Caught on the first edge after release so a noisy strap cannot
  // change the mode mid-session.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      strap_st <= HPM_STRAP_WAIT;
      host_spi <= RST_HOST_SPI;
    end else begin
      case (strap_st)
        HPM_STRAP_WAIT: begin
          host_spi <= strap_s;
          strap_st <= HPM_STRAP_HELD;
        end
        HPM_STRAP_HELD: begin
          host_spi <= host_spi;
        end
        default: begin
          strap_st <= HPM_STRAP_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host pin mux
  // ----------------------------------------------------------------
  logic held;
  assign held = (strap_st == HPM_STRAP_HELD);

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      host_spi_mode_out                  <= RST_HOST_SPI;
      host_data_or_spi_clock_pin_out     <= 1'b0;
      host_data_or_spi_clock_pin_oe_out  <= 1'b0;
      host_clock_or_select_pin_out       <= 1'b0;
      host_clock_or_select_pin_oe_out    <= 1'b0;
      iface_strap_or_host_out_pin_out    <= 1'b0;
      iface_strap_or_host_out_pin_oe_out <= 1'b0;
      host_rx_out                        <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    end else begin
      host_spi_mode_out               <= host_spi;
      host_data_or_spi_clock_pin_out  <= 1'b0;
      host_clock_or_select_pin_out    <= 1'b0;
      iface_strap_or_host_out_pin_out <= host_tx_in.spi_miso;
      if (held && host_spi) begin
        host_data_or_spi_clock_pin_oe_out  <= 1'b0;
        host_clock_or_select_pin_oe_out    <= 1'b0;
        iface_strap_or_host_out_pin_oe_out <= 1'b1;
        host_rx_out.i2c_sda  <= 1'b1;
        host_rx_out.i2c_scl  <= 1'b1;
        host_rx_out.addr_sel <= 1'b0;
        host_rx_out.spi_sck  <= host_a_s;
        host_rx_out.spi_ss_n <= host_b_s;
        host_rx_out.spi_mosi <= addr_s;
      end else begin
        // Strap pin stays an input until the mode is known, and for good in I2C mode
        host_data_or_spi_clock_pin_oe_out  <= held && host_tx_in.i2c_sda_low;
        host_clock_or_select_pin_oe_out    <= held && host_tx_in.i2c_scl_low;
        iface_strap_or_host_out_pin_oe_out <= 1'b0;
        host_rx_out.i2c_sda  <= host_a_s;
        host_rx_out.i2c_scl  <= host_b_s;
        host_rx_out.addr_sel <= addr_s;
        host_rx_out.spi_sck  <= 1'b0;
        host_rx_out.spi_ss_n <= 1'b1;
        host_rx_out.spi_mosi <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Downstream port mux
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      downstream_port_pin_out    <= DS_OE_NONE;
      downstream_port_pin_oe_out <= DS_OE_NONE;
      ds_rx_out                  <= '{1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      ds_rx_out <= '{1'b1, 1'b1, 1'b1, 1'b0};
      case (ds_mode_in)
        HPM_DS_PAR: begin
          downstream_port_pin_out    <= ds_tx_in.par;
          downstream_port_pin_oe_out <= DS_OE_PAR;
        end
        HPM_DS_I2C: begin
          downstream_port_pin_out    <= DS_OE_NONE;
          downstream_port_pin_oe_out <= {2'b00, ds_tx_in.i2c_scl_low,
                                         ds_tx_in.i2c_sda_low};
          ds_rx_out.i2c_sda <= ds_s[0];
          ds_rx_out.i2c_scl <= ds_s[1];
          ds_rx_out.irq_n   <= ds_s[2];
        end
        HPM_DS_SPI: begin
          downstream_port_pin_out    <= {ds_tx_in.spi_ss_n, 1'b0,
                                         ds_tx_in.spi_sck, ds_tx_in.spi_mosi};
          downstream_port_pin_oe_out <= DS_OE_SPI;
          ds_rx_out.spi_miso <= ds_s[2];
        end
        default: begin
          // An undefined mode releases every pin rather than guessing
          downstream_port_pin_out    <= DS_OE_NONE;
          downstream_port_pin_oe_out <= DS_OE_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // General pins, sync inputs, channel routing
  // ----------------------------------------------------------------
  logic [GPIO_N-1:0] sync_mask;
  assign sync_mask = {2'b00, ext_sync_en_in, hsync_en_in, 1'b0};

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      general_io_pins_out     <= 5'h00;
      general_io_pins_oe_out  <= 5'h00;
      general_io_val_out      <= 5'h00;
      hsync_out               <= 1'b0;
      external_sync_input_out <= 1'b0;
    end else begin
      general_io_pins_out     <= general_io_drive_in;
      general_io_pins_oe_out  <= general_io_dir_in & ~sync_mask;
      general_io_val_out      <= gpio_s;
      hsync_out               <= hsync_en_in && gpio_s[HSYNC_BIT];
      external_sync_input_out <= ext_sync_en_in && gpio_s[XSYNC_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      a_upper_remap_out <= 18'h00000;
      force_chan_en_out <= AUX_SINGLE;
    end else begin
      a_upper_remap_out <= a_upper_remap_in;
      force_chan_en_out <= force_multi_in ? AUX_ALL : AUX_SINGLE;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_irq_low_pend: assert property (
    pend |=> report_pending_irq_n_oe_out && !report_pending_irq_n_out)
    else $error("irq not asserted while report pending");

  a_irq_release: assert property (
    !pend ##1 !pend |-> !report_pending_irq_n_oe_out)
    else $error("irq held with no report pending");

  a_read_consume: assert property (
    consume && !report_post_in && pend
      |=> pending_count_out == $past(pending_count_out) - 4'h1)
    else $error("host read did not consume one report");

  a_strap_i2c_sel: assert property (
    strap_st == HPM_STRAP_WAIT && !strap_s |=> ##1 !host_spi_mode_out
      && !iface_strap_or_host_out_pin_oe_out)
    else $error("low strap did not select I2C");

  a_strap_spi_sel: assert property (
    strap_st == HPM_STRAP_WAIT && strap_s |=> ##1 host_spi_mode_out
      && iface_strap_or_host_out_pin_oe_out)
    else $error("high strap did not select SPI output");

  a_mode_latched: assert property (
    held |=> $stable(host_spi) [*8])
    else $error("host mode changed after capture");

  a_spi_pin_roles: assert property (
    held && host_spi |=> !host_data_or_spi_clock_pin_oe_out
      && !host_clock_or_select_pin_oe_out && host_rx_out.spi_sck == $past(host_a_s))
    else $error("SPI mode pins not inputs");

  a_spi_select_in: assert property (
    held && host_spi |=> host_rx_out.spi_ss_n == $past(host_b_s))
    else $error("SPI select not taken from clock pin");

  a_addr_sel_pin: assert property (
    held && !host_spi |=> host_rx_out.addr_sel == $past(addr_s)
      && host_rx_out.spi_mosi == 1'b0)
    else $error("address select not routed in I2C mode");

  a_ds_par_out: assert property (
    ds_mode_in == HPM_DS_PAR |=> downstream_port_pin_oe_out == DS_OE_PAR
      && downstream_port_pin_out == $past(ds_tx_in.par))
    else $error("parallel mode outputs wrong");

  a_ds_i2c_pins: assert property (
    ds_mode_in == HPM_DS_I2C |=> downstream_port_pin_oe_out[3:2] == 2'b00
      && ds_rx_out.irq_n == $past(ds_s[2]))
    else $error("master I2C pin roles wrong");

  a_ds_spi_pins: assert property (
    ds_mode_in == HPM_DS_SPI |=> downstream_port_pin_oe_out == DS_OE_SPI
      && downstream_port_pin_out[3] == $past(ds_tx_in.spi_ss_n))
    else $error("master SPI pin roles wrong");

  a_sync_input: assert property (
    hsync_en_in |=> !general_io_pins_oe_out[HSYNC_BIT]
      && hsync_out == $past(gpio_s[HSYNC_BIT]))
    else $error("hsync pin not an input");

  a_force_chans: assert property (
    !force_multi_in |=> force_chan_en_out == AUX_SINGLE)
    else $error("single force mode uses wrong channels");

  a_reset_state: assert property (
    disable iff (1'b0) !rst_b_in |=> !report_pending_irq_n_oe_out
      && !host_spi_mode_out && downstream_port_pin_oe_out == DS_OE_NONE)
    else $error("reset state not restored");

  c_irq_cycle: cover property (pend ##[1:200] !pend);
  c_spi_mode: cover property (held && host_spi);
  c_post_read: cover property (report_post_in && consume && pend);
  c_ds_switch: cover property (ds_mode_in == HPM_DS_I2C ##1 ds_mode_in == HPM_DS_SPI);

endmodule : hpm_pin_mux

/* File: hdl/hpm_pkg.sv */
// Shared constants and types for the host port mode and pin mux block
package hpm_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int PEND_W      = 4;
  localparam logic [PEND_W-1:0] PEND_MAX  = 4'hF;
  localparam logic [PEND_W-1:0] PEND_ZERO = 4'h0;
  localparam int DS_N        = 4;
  localparam int GPIO_N      = 5;
  localparam int AUX_N       = 4;
  localparam int A_REMAP_FIRST = 36;
  localparam int A_REMAP_LAST  = 53;
  localparam int A_REMAP_N   = A_REMAP_LAST - A_REMAP_FIRST + 1;

  // ----------------------------------------------------------------
  // Field positions and fixed pin patterns
  // ----------------------------------------------------------------
  localparam int HSYNC_BIT   = 1;
  localparam int XSYNC_BIT   = 2;
  localparam logic [DS_N-1:0]  DS_OE_PAR  = 4'hF;
  localparam logic [DS_N-1:0]  DS_OE_SPI  = 4'hB;
  localparam logic [DS_N-1:0]  DS_OE_NONE = 4'h0;
  localparam logic [AUX_N-1:0] AUX_SINGLE = 4'h1;
  localparam logic [AUX_N-1:0] AUX_ALL    = 4'hF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_IRQ_OE   = 1'b0;
  localparam logic RST_HOST_SPI = 1'b0;

  // ----------------------------------------------------------------
  // Modes, states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HPM_DS_PAR = 3'b001,
    HPM_DS_I2C = 3'b010,
    HPM_DS_SPI = 3'b100
  } hpm_ds_mode_t;

  typedef enum logic [1:0] {
    HPM_STRAP_WAIT = 2'b01,
    HPM_STRAP_HELD = 2'b10
  } hpm_strap_st_t;

  typedef struct packed {
    logic i2c_sda_low;
    logic i2c_scl_low;
    logic spi_miso;
  } hpm_host_tx_t;

  typedef struct packed {
    logic i2c_sda;
    logic i2c_scl;
    logic addr_sel;
    logic spi_sck;
    logic spi_ss_n;
    logic spi_mosi;
  } hpm_host_rx_t;

  typedef struct packed {
    logic [DS_N-1:0] par;
    logic            i2c_sda_low;
    logic            i2c_scl_low;
    logic            spi_mosi;
    logic            spi_sck;
    logic            spi_ss_n;
  } hpm_ds_tx_t;

  typedef struct packed {
    logic i2c_sda;
    logic i2c_scl;
    logic irq_n;
    logic spi_miso;
  } hpm_ds_rx_t;

endpackage : hpm_pkg

/* File: hdl/hpm_sync2.sv */
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
module hpm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    meta  <= d_in;
    q_out <= meta;
  end
endmodule : hpm_sync2

/* File: hdl/hpm_pend_ctr.sv */
// Count of reports waiting for the host
`timescale 1ns/100ps
module hpm_pend_ctr import hpm_pkg::*; (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              post_in,
  input  wire logic              consume_in,
  output logic      [PEND_W-1:0] count_out
);
  logic [PEND_W-1:0] next_count;
  logic              take;

  always_comb begin
    take       = consume_in && (count_out != PEND_ZERO);
    next_count = count_out;
    // A post in the same cycle as a read is kept, never lost
    if (post_in && !take && (count_out != PEND_MAX)) begin
      next_count = count_out + 4'h1;
    end else if (take && !post_in) begin
      next_count = count_out - 4'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      count_out <= PEND_ZERO;
    end else begin
      count_out <= next_count;
    end
  end
endmodule : hpm_pend_ctr

/* File: verification/hpm_host_model.sv */
// Host processor model: level-sensed report reads over a gated link clock
`timescale 1ns/100ps
module hpm_host_model (
  input  wire logic rst_b_in,
  input  wire logic en_in,
  input  wire logic irq_pin_in,
  output logic      link_clk_out,
  output logic      read_out
);
  initial begin
    link_clk_out = 1'b0;
    read_out     = 1'b0;
    #7;
    forever begin
      // Clock runs in reset so the link side clears, otherwise only in frames
      if (!rst_b_in || (en_in && !irq_pin_in)) begin
        read_out = rst_b_in;
        repeat (3) begin
          #40 link_clk_out = 1'b1;
          #40 link_clk_out = 1'b0;
          read_out = 1'b0;
        end
        // Slow host: long gap lets the level settle before it looks again
        #300;
      end else begin
        #40;
      end
    end
  end
endmodule : hpm_host_model

/* File: verification/tb_top.sv */
// Self-checking bench for the host port mode and pin mux block
`timescale 1ns/100ps
module tb_top import hpm_pkg::*;;
  logic clk = 1'b0;
  logic rst_b, post, en, hp_d, hp_c, hp_a, hp_s, multi, hs, xe, lclk, rd;
  logic irq_out, irq_oe, spi, d_out, d_oe, c_out, c_oe, s_out, s_oe, hsync, xsync;
  logic [PEND_W-1:0] cnt;
  logic [DS_N-1:0] dp_tb, dp_out, dp_oe, de, dq, dr;
  logic [GPIO_N-1:0] g_tb, g_drv, g_dir, g_out, g_oe, g_val, ge, gl;
  logic [A_REMAP_N-1:0] rm_in, rm_out;
  logic [AUX_N-1:0] fce;
  logic [31:0] seed = 32'h53;
  logic [31:0] r;
  hpm_host_tx_t htx;
  hpm_host_rx_t hrx;
  hpm_ds_mode_t dmode;
  hpm_ds_tx_t dtx;
  hpm_ds_rx_t drx;
  int errors = 0;
  int checks = 0;
  int qid[$];
  logic [31:0] qv[$];
  event look;
  // Released lines show the bench value, pulled-up irq reads high
  wire d_pin = d_oe ? d_out : hp_d;
  wire c_pin = c_oe ? c_out : hp_c;
  wire s_pin = s_oe ? s_out : hp_s;
  wire irq_pin = irq_oe ? irq_out : 1'b1;
  wire [DS_N-1:0] dp = (dp_oe & dp_out) | (~dp_oe & dp_tb);
  wire [GPIO_N-1:0] gp = (g_oe & g_out) | (~g_oe & g_tb);
  always #5 clk = ~clk;
  hpm_host_model i_host (.rst_b_in(rst_b), .en_in(en), .irq_pin_in(irq_pin),
    .link_clk_out(lclk), .read_out(rd));
  hpm_pin_mux i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .link_clk_in(lclk),
    .link_report_read_in(rd), .report_post_in(post), .report_pending_irq_n_out(irq_out),
    .report_pending_irq_n_oe_out(irq_oe), .pending_count_out(cnt),
    .host_data_or_spi_clock_pin_in(d_pin), .host_data_or_spi_clock_pin_out(d_out),
    .host_data_or_spi_clock_pin_oe_out(d_oe), .host_clock_or_select_pin_in(c_pin),
    .host_clock_or_select_pin_out(c_out), .host_clock_or_select_pin_oe_out(c_oe),
    .addr_select_or_host_in_pin_in(hp_a), .iface_strap_or_host_out_pin_in(s_pin),
    .iface_strap_or_host_out_pin_out(s_out), .iface_strap_or_host_out_pin_oe_out(s_oe),
    .host_tx_in(htx), .host_rx_out(hrx), .host_spi_mode_out(spi), .ds_mode_in(dmode),
    .ds_tx_in(dtx), .ds_rx_out(drx), .downstream_port_pin_in(dp),
    .downstream_port_pin_out(dp_out), .downstream_port_pin_oe_out(dp_oe),
    .general_io_pins_in(gp), .general_io_drive_in(g_drv), .general_io_dir_in(g_dir),
    .hsync_en_in(hs), .ext_sync_en_in(xe), .general_io_pins_out(g_out),
    .general_io_pins_oe_out(g_oe), .general_io_val_out(g_val), .hsync_out(hsync),
    .external_sync_input_out(xsync), .a_upper_remap_in(rm_in), .a_upper_remap_out(rm_out),
    .force_multi_in(multi), .force_chan_en_out(fce));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  function automatic logic [31:0] obs(input int id);
    case (id)
      0: return 32'(cnt);
      1: return 32'({irq_out, irq_oe});
      2: return 32'(spi);
      3: return 32'(hrx);
      4: return {26'h0, d_out, c_out, d_oe, c_oe, s_oe, s_out & s_oe};
      6: return 32'(dp_oe);
      7: return 32'(dp_oe & dp_out);
      8: return 32'(drx);
      9: return 32'(g_oe);
      10: return 32'(g_oe & g_out);
      11: return 32'(g_val);
      12: return {30'h0, hsync, xsync};
      13: return 32'(rm_out);
      default: return 32'(fce);
    endcase
  endfunction : obs

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic note(input int id, input logic [31:0] v);
    qid.push_back(id);
    qv.push_back(v);
    -> look;
  endtask : note

  always @(look) while (qid.size() > 0) chk(obs(qid.pop_front()), qv.pop_front());

  task automatic final_report();
    #1;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic do_reset(input logic strap);
    @(negedge clk);
    rst_b = 1'b0;
    hp_s = strap;
    repeat (6) @(posedge clk);
    @(negedge clk);
    note(0, 32'h0);
    note(4, 32'h0);
    note(14, 32'h1);
    rst_b = 1'b1;
  endtask : do_reset

  task automatic host_case(input logic m);
    r = xorshift();
    {hp_d, hp_c, hp_a} = r[2:0];
    htx = r[5:3];
    // Strap moves after capture; the mode must not follow it
    hp_s = ~hp_s;
    settle();
    note(2, 32'(m));
    if (m) begin
      note(3, {26'h0, 3'b110, hp_d, hp_c, hp_a});
      note(4, {30'h0, 1'b1, htx.spi_miso});
    end else begin
      note(3, {26'h0, hp_d & ~htx.i2c_sda_low, hp_c & ~htx.i2c_scl_low, hp_a, 3'b010});
      note(4, {28'h0, htx.i2c_sda_low, htx.i2c_scl_low, 2'b00});
    end
  endtask : host_case

  initial begin
    {rst_b, post, en, hp_d, hp_c, hp_a, hp_s, multi, hs, xe} = '0;
    {htx, dtx, dp_tb, g_tb, g_drv, g_dir, rm_in} = '0;
    dmode = HPM_DS_PAR;
    do_reset(1'b0);
    settle();
    repeat (3) host_case(1'b0);
    $display("test i2c host mode done");
    // Three back-to-back reports, then the host drains them by level
    post = 1'b1;
    repeat (3) @(negedge clk);
    post = 1'b0;
    settle();
    note(0, 32'h3);
    note(1, 32'h1);
    en = 1'b1;
    for (int n = 0; irq_oe !== 1'b0; n++) begin
      if (n == 500) begin
        chk(32'(irq_oe), 32'h0);
        final_report();
      end
      @(negedge clk);
    end
    repeat (60) @(negedge clk);
    note(0, 32'h0);
    note(1, 32'h0);
    en = 1'b0;
    $display("test report interrupt done");
    for (int i = 0; i < 12; i++) begin
      r = xorshift();
      dmode = hpm_ds_mode_t'(3'(1 << (i % 4)));
      dtx = r[8:0];
      dp_tb = r[12:9];
      {g_drv, g_dir, g_tb} = r[27:13];
      {hs, xe, multi} = r[30:28];
      rm_in = r[31:14];
      settle();
      case (dmode)
        HPM_DS_PAR: begin de = DS_OE_PAR; dq = dtx.par; dr = 4'hE; end
        HPM_DS_I2C: begin
          de = {2'b00, dtx.i2c_scl_low, dtx.i2c_sda_low};
          dq = 4'h0;
          dr = {dp_tb[0] & ~de[0], dp_tb[1] & ~de[1], dp_tb[2], 1'b0};
        end
        HPM_DS_SPI: begin
          de = DS_OE_SPI;
          dq = {dtx.spi_ss_n, 1'b0, dtx.spi_sck, dtx.spi_mosi};
          dr = {3'b111, dp_tb[2]};
        end
        default: begin de = DS_OE_NONE; dq = 4'h0; dr = 4'hE; end
      endcase
      note(6, 32'(de));
      note(7, 32'(dq & de));
      if (de != DS_OE_NONE) note(8, 32'(dr));
      ge = g_dir & ~{2'b00, xe, hs, 1'b0};
      gl = (ge & g_drv) | (~ge & g_tb);
      note(9, 32'(ge));
      note(10, 32'(ge & g_drv));
      note(11, 32'(gl));
      note(12, {30'h0, hs & gl[HSYNC_BIT], xe & gl[XSYNC_BIT]});
      note(13, 32'(rm_in));
      note(14, multi ? 32'(AUX_ALL) : 32'(AUX_SINGLE));
    end
    $display("test pin mux done");
    do_reset(1'b1);
    settle();
    repeat (3) host_case(1'b1);
    $display("test spi host mode done");
    final_report();
  end
endmodule : tb_top
